// File: include/twm_pkg.sv
// Package with register map, field layout, modes and constants of the waveform timer.
package twm_pkg;

   // APB byte offsets of the register words.
   localparam logic [7:0] ADDR_OUTPUT_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_SECOND = 8'h04;
   localparam logic [7:0] ADDR_COMPARE_A      = 8'h08;
   localparam logic [7:0] ADDR_COMPARE_B      = 8'h0C;
   localparam logic [7:0] ADDR_CAPTURE        = 8'h10;
   localparam logic [7:0] ADDR_COUNT          = 8'h14;
   localparam logic [7:0] ADDR_STATUS         = 8'h18;
   localparam logic [7:0] ADDR_PIN_DIR        = 8'h1C;

   // Field positions and masks.
   localparam int         POS_CHAN_A_MODE     = 6;
   localparam int         POS_CHAN_B_MODE     = 4;
   localparam logic [7:0] MASK_OUTPUT_CONTROL = 8'hF3;
   localparam logic [7:0] MASK_CONTROL_SECOND = 8'h18;
   localparam int         POS_MODE_HIGH       = 3;

   // Values after reset.
   localparam logic [7:0]  RESET_CONTROL = 8'h00;
   localparam logic [15:0] RESET_WORD    = 16'h0000;

   // Fixed tops and limits.
   localparam logic [15:0] TOP_MAX    = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT   = 16'h00FF;
   localparam logic [15:0] TOP_9BIT   = 16'h01FF;
   localparam logic [15:0] TOP_10BIT  = 16'h03FF;
   localparam logic [15:0] BOTTOM     = 16'h0000;

   // Waveform mode encodings.
   localparam logic [3:0] WM_NORMAL   = 4'h0;
   localparam logic [3:0] WM_PC8      = 4'h1;
   localparam logic [3:0] WM_PC9      = 4'h2;
   localparam logic [3:0] WM_PC10     = 4'h3;
   localparam logic [3:0] WM_CTC_A    = 4'h4;
   localparam logic [3:0] WM_FAST8    = 4'h5;
   localparam logic [3:0] WM_FAST9    = 4'h6;
   localparam logic [3:0] WM_FAST10   = 4'h7;
   localparam logic [3:0] WM_PFC_CAP  = 4'h8;
   localparam logic [3:0] WM_PFC_A    = 4'h9;
   localparam logic [3:0] WM_PC_CAP   = 4'hA;
   localparam logic [3:0] WM_PC_A     = 4'hB;
   localparam logic [3:0] WM_CTC_CAP  = 4'hC;
   localparam logic [3:0] WM_FAST_CAP = 4'hE;
   localparam logic [3:0] WM_FAST_A   = 4'hF;

   // Compare output mode encodings.
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   typedef enum logic [2:0]
   {
      SEQ_SINGLE = 3'b001,
      SEQ_FAST   = 3'b010,
      SEQ_DUAL   = 3'b100
   } twm_seq_t;

   // Decoded behaviour of the selected waveform mode.
   typedef struct packed
   {
      twm_seq_t   seq;
      logic [1:0] top_src;      // 0 fixed, 1 capture, 2 compare A
      logic [15:0] fixed_top;
      logic       load_at_top;
      logic       load_at_bottom;
      logic       ovf_at_top;
      logic       ovf_at_bottom;
      logic       clear_on_match;
      logic       a_toggle_ok;
   } twm_mode_t;

   // Per-channel events handed to the output unit.
   typedef struct packed
   {
      logic match;
      logic at_top;
      logic up;
   } twm_event_t;

   localparam logic [1:0] TOP_FIXED   = 2'h0;
   localparam logic [1:0] TOP_CAPTURE = 2'h1;
   localparam logic [1:0] TOP_COMP_A  = 2'h2;

endpackage

// File: hdl/twm_mode_decode.sv
// Decoder from the 4-bit waveform mode to its count, top and update behaviour.
`timescale 1ns/1ps
module twm_mode_decode
   import twm_pkg::*;
(
   input  wire logic [3:0] waveform_mode,
   output twm_mode_t       mode_info
);

   always_comb
   begin
      mode_info = '{seq: SEQ_SINGLE, top_src: TOP_FIXED, fixed_top: TOP_MAX,
                    load_at_top: 1'b0, load_at_bottom: 1'b0, ovf_at_top: 1'b0,
                    ovf_at_bottom: 1'b0, clear_on_match: 1'b0, a_toggle_ok: 1'b0};
      case (waveform_mode)
         WM_NORMAL, WM_CTC_A, WM_CTC_CAP:
         begin
            // Immediate compare update and overflow at MAX.
            mode_info.clear_on_match = (waveform_mode != WM_NORMAL);
            mode_info.top_src = (waveform_mode == WM_CTC_A) ? TOP_COMP_A :
                                (waveform_mode == WM_CTC_CAP) ? TOP_CAPTURE : TOP_FIXED;
         end
         WM_PC8, WM_PC9, WM_PC10, WM_PC_CAP, WM_PC_A:
         begin
            mode_info.seq = SEQ_DUAL;
            mode_info.load_at_top = 1'b1;
            mode_info.ovf_at_bottom = 1'b1;
            mode_info.fixed_top = (waveform_mode == WM_PC8) ? TOP_8BIT :
                                  (waveform_mode == WM_PC9) ? TOP_9BIT : TOP_10BIT;
            mode_info.top_src = (waveform_mode == WM_PC_CAP) ? TOP_CAPTURE :
                                (waveform_mode == WM_PC_A) ? TOP_COMP_A : TOP_FIXED;
            mode_info.a_toggle_ok = (waveform_mode == WM_PC_CAP) || (waveform_mode == WM_PC_A);
         end
         WM_FAST8, WM_FAST9, WM_FAST10, WM_FAST_CAP, WM_FAST_A:
         begin
            mode_info.seq = SEQ_FAST;
            mode_info.load_at_top = 1'b1;
            mode_info.ovf_at_top = 1'b1;
            mode_info.fixed_top = (waveform_mode == WM_FAST8) ? TOP_8BIT :
                                  (waveform_mode == WM_FAST9) ? TOP_9BIT : TOP_10BIT;
            mode_info.top_src = (waveform_mode == WM_FAST_CAP) ? TOP_CAPTURE :
                                (waveform_mode == WM_FAST_A) ? TOP_COMP_A : TOP_FIXED;
            mode_info.a_toggle_ok = (waveform_mode == WM_FAST_CAP) || (waveform_mode == WM_FAST_A);
         end
         WM_PFC_CAP, WM_PFC_A:
         begin
            mode_info.seq = SEQ_DUAL;
            mode_info.load_at_bottom = 1'b1;
            mode_info.ovf_at_bottom = 1'b1;
            mode_info.a_toggle_ok = 1'b1;
            mode_info.top_src = (waveform_mode == WM_PFC_CAP) ? TOP_CAPTURE : TOP_COMP_A;
         end
         default:
         begin
            // Reserved mode counts like normal mode.
            mode_info.seq = SEQ_SINGLE;
         end
      endcase
   end

endmodule

// File: hdl/twm_output_unit.sv
// One compare-output waveform channel with its pin take-over logic.
`timescale 1ns/1ps
module twm_output_unit
   import twm_pkg::*;
#(
   parameter bit CHAN_IS_A = 1'b1
)
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clk_en,
   input  wire logic       tick,
   input  wire logic [1:0] out_mode,
   input  wire twm_mode_t  mode_info,
   input  wire twm_event_t ev,
   input  wire logic       cmp_is_top,
   input  wire logic       cmp_is_bottom,
   input  wire logic       pin_dir_out,
   output logic            wave_out,
   output logic            wave_oe
);

   logic next_wave;
   logic toggle_ok;

   assign toggle_ok = CHAN_IS_A && (mode_info.seq == SEQ_SINGLE || mode_info.a_toggle_ok);

   always_comb
   begin
      next_wave = wave_out;
      case (mode_info.seq)
         SEQ_SINGLE:
         begin
            if (ev.match)
            begin
               case (out_mode)
                  COM_TOGGLE: next_wave = ~wave_out;
                  COM_CLEAR:  next_wave = 1'b0;
                  COM_SET:    next_wave = 1'b1;
                  default:    next_wave = wave_out;
               endcase
            end
         end
         SEQ_FAST:
         begin
            if (out_mode == COM_TOGGLE)
            begin
               if (ev.match && toggle_ok)
                  next_wave = ~wave_out;
            end
            else if (out_mode[1])
            begin
               // Top action wins; a match at top is ignored.
               if (ev.at_top)
                  next_wave = ~out_mode[0];
               else if (ev.match && !cmp_is_top)
                  next_wave = out_mode[0];
            end
         end
         SEQ_DUAL:
         begin
            if (out_mode == COM_TOGGLE)
            begin
               if (ev.match && toggle_ok)
                  next_wave = ~wave_out;
            end
            else if (out_mode[1])
            begin
               // Extremes hold a steady level.
               if (cmp_is_bottom)
                  next_wave = out_mode[0];
               else if (cmp_is_top)
                  next_wave = ~out_mode[0];
               else if (ev.match)
                  next_wave = ev.up ? out_mode[0] : ~out_mode[0];
            end
         end
         default: next_wave = wave_out;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wave_out <= 1'b0;
      else if (clk_en && tick)
         wave_out <= next_wave;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wave_oe <= 1'b0;
      else if (clk_en)
         wave_oe <= (out_mode != COM_OFF) && pin_dir_out;
   end

   a_oe_needs_dir: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en ##1 wave_oe |-> $past(pin_dir_out) && ($past(out_mode) != COM_OFF))
      else $error("output enabled without direction or mode");

   a_fast_top_act: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && tick && mode_info.seq == SEQ_FAST && out_mode[1] && ev.at_top)
      |=> wave_out == ~$past(out_mode[0]))
      else $error("fast pwm top action wrong");

   a_dual_match: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && tick && mode_info.seq == SEQ_DUAL && out_mode[1] && ev.match
       && !cmp_is_top && !cmp_is_bottom) |=> wave_out == ($past(ev.up) ~^ $past(out_mode[0])))
      else $error("dual slope match action wrong");

   a_b_no_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && tick && !CHAN_IS_A && mode_info.seq != SEQ_SINGLE && out_mode == COM_TOGGLE)
      |=> $stable(wave_out))
      else $error("channel b toggled in pwm mode");

endmodule

// File: hdl/twm_timer.sv
// Top of the 16-bit waveform timer: APB registers, counter and two output channels.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module twm_timer
   import twm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        timer_tick_enable,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             wave_out_a,
   output logic             wave_oe_a,
   output logic             wave_out_b,
   output logic             wave_oe_b
);

   logic [7:0]  waveform_output_control;
   logic [7:0]  timer_control_second;
   logic [15:0] compare_value_a;
   logic [15:0] compare_value_b;
   logic [15:0] buffer_a;
   logic [15:0] buffer_b;
   logic [15:0] capture_value;
   logic [15:0] count_value;
   logic        count_down;
   logic        overflow_flag;
   logic [1:0]  compare_match_flag;
   logic [1:0]  pin_dir;
   logic [3:0]  waveform_mode;
   twm_mode_t   mode_info;
   logic [15:0] top;
   logic        tick;
   logic        at_top;
   logic        at_bottom;
   logic        match_a;
   logic        match_b;
   twm_event_t  ev_a;
   twm_event_t  ev_b;
   logic        access;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic [15:0] next_count;
   logic        next_down;
   logic [31:0] next_rdata;

   assign waveform_mode = {timer_control_second[POS_MODE_HIGH +: 2],
                           waveform_output_control[1:0]};

   twm_mode_decode u_decode
   (
      .waveform_mode (waveform_mode),
      .mode_info     (mode_info)
   );

   function automatic logic [15:0] fixed_mask(input logic [15:0] v, input twm_mode_t m);
      fixed_mask = (m.top_src == TOP_FIXED && m.seq != SEQ_SINGLE) ? (v & m.fixed_top) : v;
   endfunction

   assign top = (mode_info.top_src == TOP_CAPTURE) ? capture_value :
                (mode_info.top_src == TOP_COMP_A)  ? compare_value_a : mode_info.fixed_top;
   assign tick      = clk_en && timer_tick_enable;
   assign at_top    = (count_value == top);
   assign at_bottom = (count_value == BOTTOM);
   assign match_a   = (count_value == compare_value_a);
   assign match_b   = (count_value == compare_value_b);
   assign ev_a      = '{match: match_a, at_top: at_top, up: !count_down};
   assign ev_b      = '{match: match_b, at_top: at_top, up: !count_down};

   // APB decode; slave answers in the access cycle with no wait states.
   assign access = psel && penable;
   assign wr     = access && pwrite;
   assign rd     = access && !pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_PIN_DIR);

   // Count sequence.
   always_comb
   begin
      next_count = count_value + 16'h0001;
      next_down  = count_down;
      case (mode_info.seq)
         SEQ_SINGLE:
         begin
            next_down = 1'b0;
            if (mode_info.clear_on_match && at_top)
               next_count = BOTTOM;
         end
         SEQ_FAST:
         begin
            next_down = 1'b0;
            if (at_top || count_value > top)
               next_count = BOTTOM;
         end
         SEQ_DUAL:
         begin
            if (!count_down && (at_top || count_value > top))
            begin
               next_down  = 1'b1;
               next_count = count_value - 16'h0001;
            end
            else if (count_down && at_bottom)
            begin
               next_down  = 1'b0;
               next_count = count_value + 16'h0001;
            end
            else if (count_down)
               next_count = count_value - 16'h0001;
         end
         default: next_down = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_value <= RESET_WORD;
         count_down  <= 1'b0;
      end
      else if (wr && mapped && paddr == ADDR_COUNT && clk_en)
         count_value <= pwdata[15:0];
      else if (tick)
      begin
         count_value <= next_count;
         count_down  <= next_down;
      end
   end

   // Control registers; reserved bits are not stored.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         waveform_output_control <= RESET_CONTROL;
         timer_control_second    <= RESET_CONTROL;
         capture_value           <= RESET_WORD;
         pin_dir                 <= 2'h0;
      end
      else if (clk_en && wr && mapped)
      begin
         case (paddr)
            ADDR_OUTPUT_CONTROL: waveform_output_control <= pwdata[7:0] & MASK_OUTPUT_CONTROL;
            ADDR_CONTROL_SECOND: timer_control_second <= pwdata[7:0] & MASK_CONTROL_SECOND;
            ADDR_CAPTURE:        capture_value <= pwdata[15:0];
            ADDR_PIN_DIR:        pin_dir <= pwdata[1:0];
            default:             pin_dir <= pin_dir;
         endcase
      end
   end

   // Compare buffers: immediate in non-PWM modes, else loaded at top or bottom.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         buffer_a <= RESET_WORD;
         buffer_b <= RESET_WORD;
      end
      else if (clk_en && wr && mapped)
      begin
         if (paddr == ADDR_COMPARE_A)
            buffer_a <= fixed_mask(pwdata[15:0], mode_info);
         if (paddr == ADDR_COMPARE_B)
            buffer_b <= fixed_mask(pwdata[15:0], mode_info);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compare_value_a <= RESET_WORD;
         compare_value_b <= RESET_WORD;
      end
      else if (clk_en && mode_info.seq == SEQ_SINGLE)
      begin
         compare_value_a <= buffer_a;
         compare_value_b <= buffer_b;
      end
      else if (tick && ((mode_info.load_at_top && at_top) ||
                        (mode_info.load_at_bottom && at_bottom)))
      begin
         compare_value_a <= buffer_a;
         compare_value_b <= buffer_b;
      end
   end

   // Status flags; a new event wins over a clear written in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         overflow_flag      <= 1'b0;
         compare_match_flag <= 2'h0;
      end
      else if (clk_en)
      begin
         if (wr && mapped && paddr == ADDR_STATUS)
         begin
            overflow_flag      <= overflow_flag & ~pwdata[0];
            compare_match_flag <= compare_match_flag & ~pwdata[2:1];
         end
         if (tick && ((mode_info.seq == SEQ_SINGLE && count_value == TOP_MAX) ||
                      (mode_info.ovf_at_top && at_top) ||
                      (mode_info.ovf_at_bottom && at_bottom && count_down)))
            overflow_flag <= 1'b1;
         if (tick && match_a)
            compare_match_flag[0] <= 1'b1;
         if (tick && match_b)
            compare_match_flag[1] <= 1'b1;
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         ADDR_OUTPUT_CONTROL: next_rdata[7:0] = waveform_output_control;
         ADDR_CONTROL_SECOND: next_rdata[7:0] = timer_control_second;
         ADDR_COMPARE_A:      next_rdata[15:0] = buffer_a;
         ADDR_COMPARE_B:      next_rdata[15:0] = buffer_b;
         ADDR_CAPTURE:        next_rdata[15:0] = capture_value;
         ADDR_COUNT:          next_rdata[15:0] = count_value;
         ADDR_STATUS:         next_rdata[2:0] = {compare_match_flag, overflow_flag};
         ADDR_PIN_DIR:        next_rdata[1:0] = pin_dir;
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   // Outputs are registered, so read data is captured in the setup cycle and presented in the access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         prdata  <= (psel && !penable && !pwrite) ? next_rdata : prdata;
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   twm_output_unit #(.CHAN_IS_A(1'b1)) u_chan_a
   (
      .pclk          (pclk),
      .presetn       (presetn),
      .clk_en        (clk_en),
      .tick          (timer_tick_enable),
      .out_mode      (waveform_output_control[POS_CHAN_A_MODE +: 2]),
      .mode_info     (mode_info),
      .ev            (ev_a),
      .cmp_is_top    (compare_value_a == top),
      .cmp_is_bottom (compare_value_a == BOTTOM),
      .pin_dir_out   (pin_dir[0]),
      .wave_out      (wave_out_a),
      .wave_oe       (wave_oe_a)
   );

   twm_output_unit #(.CHAN_IS_A(1'b0)) u_chan_b
   (
      .pclk          (pclk),
      .presetn       (presetn),
      .clk_en        (clk_en),
      .tick          (timer_tick_enable),
      .out_mode      (waveform_output_control[POS_CHAN_B_MODE +: 2]),
      .mode_info     (mode_info),
      .ev            (ev_b),
      .cmp_is_top    (compare_value_b == top),
      .cmp_is_bottom (compare_value_b == BOTTOM),
      .pin_dir_out   (pin_dir[1]),
      .wave_out      (wave_out_b),
      .wave_oe       (wave_oe_b)
   );

   sequence s_tick_at_top;
      tick && at_top && mode_info.seq == SEQ_FAST;
   endsequence

   a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!tick && !wr) |=> $stable(count_value))
      else $error("counter moved without tick");

   a_fast_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      s_tick_at_top and !wr |=> count_value == BOTTOM && overflow_flag)
      else $error("fast pwm did not wrap with overflow");

   a_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !wr && mode_info.clear_on_match && at_top) |=> count_value == BOTTOM)
      else $error("clear on match failed");

   a_resv_zero: assert property (@(posedge pclk) disable iff (!presetn)
      waveform_output_control[3:2] == 2'h0)
      else $error("reserved bits not zero");

endmodule

// File: testbench/twm_port_model.sv
// Model of the two port pins that the waveform outputs may take over.
`timescale 1ns/1ps
module twm_port_model
(
   input  wire logic [1:0] wave_out,
   input  wire logic [1:0] wave_oe,
   input  wire logic [1:0] port_out,
   output logic      [1:0] pin
);
   // A pin shows the waveform only while its driver is on, else the plain port value.
   assign pin = (wave_oe & wave_out) | (~wave_oe & port_out);
endmodule

// File: testbench/twm_timer_tb_top.sv
// Self-checking testbench of the waveform timer over its register bus.
`timescale 1ns/1ps
module twm_timer_tb_top;
   import twm_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        tte = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wa, oa, wb, ob;
   logic [1:0]  pin;
   logic [31:0] rdata;
   logic        rerr;
   int          mismatches = 0;
   int          checks = 0;
   int          cycles = 0;

   twm_timer twm_timer_i (.pclk(pclk), .presetn(presetn), .clk_en(ce),
      .timer_tick_enable(tte), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wave_out_a(wa), .wave_oe_a(oa), .wave_out_b(wb),
      .wave_oe_b(ob));
   // Port A idles low and port B high, so only a take-over can raise pin A.
   twm_port_model twm_port_model_i (.wave_out({wb, wa}), .wave_oe({ob, oa}),
      .port_out(2'b10), .pin(pin));

   initial
   begin
      forever #10 pclk = ~pclk;
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         mismatches = mismatches + 1;
         tally_and_finish();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Bus transfer: request held until pready is sampled high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk) tte <= 1'b1;
      @(posedge pclk) tte <= 1'b0;
      @(negedge pclk);
   endtask

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_OUTPUT_CONTROL, 32'h0);
      chk("ctrl reset", rdata, 32'h00000000);
      apb(1'b1, ADDR_OUTPUT_CONTROL, 32'h000000FF);
      apb(1'b0, ADDR_OUTPUT_CONTROL, 32'h0);
      chk("ctrl reserved", rdata, 32'h000000F3);
      apb(1'b1, ADDR_CONTROL_SECOND, 32'h000000FF);
      apb(1'b0, ADDR_CONTROL_SECOND, 32'h0);
      chk("mode high", rdata, 32'h00000018);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", {31'h0, rerr}, 32'h00000001);
      $display("Test registers done");
      // Mode 0 with channel A toggling on match at 5.
      apb(1'b1, ADDR_CONTROL_SECOND, 32'h0);
      apb(1'b1, ADDR_OUTPUT_CONTROL, 32'h00000040);
      apb(1'b1, ADDR_PIN_DIR, 32'h00000001);
      apb(1'b1, ADDR_COMPARE_A, 32'h00000005);
      apb(1'b1, ADDR_COUNT, 32'h0);
      tick(8);
      chk("toggle pin", {30'h0, pin}, 32'h00000003);
      chk("oe a b", {30'h0, ob, oa}, 32'h00000001);
      chk("wave b off", {31'h0, wb}, 32'h00000000);
      apb(1'b0, ADDR_COUNT, 32'h0);
      chk("count", rdata, 32'h00000008);
      apb(1'b1, ADDR_PIN_DIR, 32'h0);
      // The enable is registered one cycle after the direction bit.
      repeat (2) @(negedge pclk);
      chk("oe dir off", {31'h0, oa}, 32'h00000000);
      $display("Test normal done");
      // Fast 8-bit PWM, channel A clears on match at 0x10, sets at top.
      apb(1'b1, ADDR_PIN_DIR, 32'h00000001);
      apb(1'b1, ADDR_OUTPUT_CONTROL, 32'h00000081);
      apb(1'b1, ADDR_CONTROL_SECOND, 32'h00000008);
      apb(1'b1, ADDR_COMPARE_A, 32'h00000010);
      apb(1'b1, ADDR_STATUS, 32'h00000007);
      apb(1'b1, ADDR_COUNT, 32'h00000004);
      tick(2);
      chk("old compare", {31'h0, wa}, 32'h00000000);
      apb(1'b1, ADDR_COUNT, 32'h000000FE);
      tick(2);
      chk("set at top", {31'h0, wa}, 32'h00000001);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("ovf at top", {31'h0, rdata[0]}, 32'h00000001);
      apb(1'b0, ADDR_COUNT, 32'h0);
      chk("wrap", rdata, 32'h00000000);
      tick(17);
      chk("clear match", {31'h0, wa}, 32'h00000000);
      @(posedge pclk) ce <= 1'b0;
      tick(3);
      @(posedge pclk) ce <= 1'b1;
      apb(1'b0, ADDR_COUNT, 32'h0);
      chk("frozen count", rdata, 32'h00000011);
      $display("Test fast pwm done");
      // Phase correct, top from capture 8: A clears up, sets down; B toggle is refused.
      apb(1'b1, ADDR_OUTPUT_CONTROL, 32'h00000092);
      apb(1'b1, ADDR_CONTROL_SECOND, 32'h00000010);
      apb(1'b1, ADDR_CAPTURE, 32'h00000008);
      apb(1'b1, ADDR_COMPARE_A, 32'h00000003);
      apb(1'b1, ADDR_STATUS, 32'h00000007);
      apb(1'b1, ADDR_COUNT, 32'h0);
      tick(14);
      chk("down match set", {31'h0, wa}, 32'h00000001);
      tick(6);
      chk("up match clear", {31'h0, wa}, 32'h00000000);
      chk("b toggle off", {31'h0, wb}, 32'h00000000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("ovf at bottom", {31'h0, rdata[0]}, 32'h00000001);
      $display("Test dual slope done");
      tally_and_finish();
   end
endmodule
